// ---- rtl/mrl_regs.svh ----
// Register indices, field positions, reset values and load layout of the axis reset loader
`ifndef MRL_REGS_SVH
`define MRL_REGS_SVH

// ----------------------------------------------------------------------------
// Per-axis register indices (reg_addr[4:0]); reg_addr[5] selects the axis
// ----------------------------------------------------------------------------
`define MRL_REG_AXIS_EVENT_STATUS   5'h00
`define MRL_REG_LOGICAL_POSITION    5'h01
`define MRL_REG_PHYSICAL_POSITION   5'h02
`define MRL_REG_CURRENT_SPEED       5'h03
`define MRL_REG_INSTRUCTION_WORD    5'h04
`define MRL_REG_TARGET_POSITION     5'h05
`define MRL_REG_MOVE_DISTANCE       5'h06
`define MRL_REG_LOWER_SPEED         5'h07
`define MRL_REG_UPPER_SPEED         5'h08
`define MRL_REG_SPEED_RAMP_RATE     5'h09
`define MRL_REG_SYNC_INSTRUCTION    5'h0A
`define MRL_REG_SYNC_TRIGGER_SETUP  5'h0B
`define MRL_REG_POSITIVE_LIMIT      5'h0C
`define MRL_REG_NEGATIVE_LIMIT      5'h0D
`define MRL_REG_PROPERTY_GROUP_ONE  5'h0E
`define MRL_REG_PROPERTY_GROUP_TWO  5'h0F
`define MRL_REG_WRITE_ASSIST        5'h10
`define MRL_NUM_REGS                17

// ----------------------------------------------------------------------------
// Loader status register and its fields
// ----------------------------------------------------------------------------
`define MRL_LDR_STATUS_ADDR         8'h3F
`define MRL_LDR_BUSY_BIT            0
`define MRL_LDR_DONE_BIT            1

// ----------------------------------------------------------------------------
// Reset values and load layout
// ----------------------------------------------------------------------------
`define MRL_ZERO_INIT               24'h000000
`define MRL_PAT_WORDS               5
`define MRL_SET_WORDS               5

`endif

// ---- rtl/mrl_pkg.sv ----
// Types shared by the axis reset loader
package mrl_pkg;

   typedef enum logic [1:0] {
      LD_START = 2'b00,
      LD_RUN   = 2'b01,
      LD_DRAIN = 2'b10,
      LD_DONE  = 2'b11
   } mrl_state_t;

   typedef struct packed {
      logic        valid;
      logic        axis;
      logic [15:0] step;
   } mrl_stage_t;

endpackage

// ---- rtl/mrl_pattern_mem.sv ----
// One axis's pattern memory: write port and registered read port
`timescale 1ns/100ps
`default_nettype none

module mrl_pattern_mem #(
   parameter int DEPTH = 80,
   parameter int AW    = 7,
   parameter int DW    = 24
) (
   input  wire logic          mclk,     // System clock
   input  wire logic          nrst,     // Asynchronous reset, active low
   input  wire logic          wr_en,    // Write strobe
   input  wire logic [AW-1:0] wr_addr,  // Write word address
   input  wire logic [DW-1:0] wr_data,  // Write data
   input  wire logic [AW-1:0] rd_addr,  // Read word address
   output logic      [DW-1:0] rd_data   // Read data, one cycle after address
);

   logic [DW-1:0] mem [DEPTH];
   logic [DW-1:0] rd_data_d;

   always_comb begin
      rd_data_d = mem[rd_addr];
   end

   always_ff @(posedge mclk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rd_data <= '0;
      end else begin
         rd_data <= rd_data_d;
      end
   end

endmodule

`default_nettype wire

// ---- rtl/mrl_loader.sv ----
// Reset-time loader of the two-axis motion register set from the on-chip flash image
`timescale 1ns/100ps
`default_nettype none
`include "mrl_regs.svh"

module mrl_loader import mrl_pkg::*; #(
   parameter int N_PAT = 16,
   parameter int FAW   = 12
) (
   input  wire logic           mclk,         // System clock, 20 MHz
   input  wire logic           nrst,         // Asynchronous reset, active low
   input  wire logic [7:0]     reg_addr,     // Register index
   input  wire logic [31:0]    reg_wdata,    // Register write data
   input  wire logic           reg_wr,       // Write strobe
   input  wire logic           reg_rd,       // Read strobe
   output logic      [31:0]    reg_rdata,    // Read data, cycle after strobe
   output logic                busy,         // High while loading
   output logic      [FAW-1:0] flash_addr,   // Flash word address
   output logic                flash_rd,     // Flash read strobe
   input  wire logic [23:0]    flash_rdata   // Flash data, cycle after strobe
);

   // -------------------------------------------------------------------------
   // Load layout
   // -------------------------------------------------------------------------
   // Per axis: N_PAT*5 pattern words, then 5 saved settings words.
   // Steps from SET_END on read pattern entry 0 back into the motion registers.
   localparam int PW      = N_PAT * `MRL_PAT_WORDS;
   localparam int SET_END = PW + `MRL_SET_WORDS;
   localparam int TOT     = SET_END + `MRL_PAT_WORDS;
   localparam int PAW     = $clog2(PW);

   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   mrl_state_t     st_q, st_d;
   logic [15:0]    step_q, step_d;
   logic           axis_q, axis_d;
   mrl_stage_t     s1_q, s1_d;
   mrl_stage_t     s2_q, s2_d;
   logic           flash_rd_d;
   logic [FAW-1:0] flash_addr_d;
   logic           busy_d;
   logic [31:0]    reg_rdata_d;
   logic [23:0]    regs_q [2][`MRL_NUM_REGS];
   logic [23:0]    regs_d [2][`MRL_NUM_REGS];
   logic [23:0]    pm_rdata [2];
   logic [PAW-1:0] pm_raddr;
   logic [PAW-1:0] pm_waddr;
   logic [4:0]     cap_idx;
   logic           bus_hit;

   // -------------------------------------------------------------------------
   // Pattern memories, one per axis
   // -------------------------------------------------------------------------
   // Addresses park at 0 outside their phase so no access runs past the last entry
   always_comb begin
      pm_raddr = '0;
      pm_waddr = '0;
      if (s1_q.step >= 16'(SET_END)) begin
         pm_raddr = PAW'(s1_q.step - 16'(SET_END));
      end
      if (s2_q.step < 16'(PW)) begin
         pm_waddr = PAW'(s2_q.step);
      end
   end

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_axis
         logic pm_we;
         assign pm_we = s2_q.valid && (s2_q.axis == 1'(g)) && (s2_q.step < 16'(PW));
         mrl_pattern_mem #(
            .DEPTH (PW),
            .AW    (PAW),
            .DW    (24)
         ) u_pm (
            .mclk    (mclk),
            .nrst    (nrst),
            .wr_en   (pm_we),
            .wr_addr (pm_waddr),
            .wr_data (flash_rdata),
            .rd_addr (pm_raddr),
            .rd_data (pm_rdata[g])
         );
      end
   endgenerate

   // -------------------------------------------------------------------------
   // Load sequencer
   // -------------------------------------------------------------------------
   always_comb begin
      st_d   = st_q;
      step_d = step_q;
      axis_d = axis_q;
      s1_d   = '0;
      case (st_q)
         LD_START: begin
            st_d = LD_RUN;
         end
         LD_RUN: begin
            s1_d.valid = 1'b1;
            s1_d.axis  = axis_q;
            s1_d.step  = step_q;
            if (step_q == 16'(TOT - 1)) begin
               step_d = '0;
               if (axis_q) begin
                  st_d = LD_DRAIN;
               end else begin
                  axis_d = 1'b1;
               end
            end else begin
               step_d = step_q + 16'h0001;
            end
         end
         LD_DRAIN: begin
            if (!s1_q.valid && !s2_q.valid) begin
               st_d = LD_DONE;
            end
         end
         LD_DONE: begin
            st_d = LD_DONE;
         end
         default: begin
            st_d = LD_START;
         end
      endcase
      s2_d = s1_q;
      // Steps below SET_END fetch from flash, the rest replay entry 0 from pattern memory
      // flash reads for pattern words and saved settings
      flash_rd_d   = s1_d.valid && (s1_d.step < 16'(SET_END));
      flash_addr_d = s1_d.axis ? FAW'(SET_END) + FAW'(s1_d.step) : FAW'(s1_d.step);
      busy_d = (st_d != LD_DONE);
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         st_q       <= LD_START;
         step_q     <= '0;
         axis_q     <= 1'b0;
         s1_q       <= '0;
         s2_q       <= '0;
         flash_rd   <= 1'b0;
         flash_addr <= '0;
         busy       <= 1'b1;
      end else begin
         st_q       <= st_d;
         step_q     <= step_d;
         axis_q     <= axis_d;
         s1_q       <= s1_d;
         s2_q       <= s2_d;
         flash_rd   <= flash_rd_d;
         flash_addr <= flash_addr_d;
         busy       <= busy_d;
      end
   end

   // -------------------------------------------------------------------------
   // Register file: load capture and bus access
   // -------------------------------------------------------------------------
   assign bus_hit = (reg_addr[7:6] == 2'b00) && (reg_addr[4:0] < 5'(`MRL_NUM_REGS));

   always_comb begin
      regs_d  = regs_q;
      cap_idx = '0;
      if (s2_q.valid && (s2_q.step >= 16'(PW)) && (s2_q.step < 16'(SET_END))) begin
         // settings come straight from the saved flash image
         // image is whatever the last save command wrote
         // each axis has its own settings block in flash
         cap_idx = `MRL_REG_SYNC_TRIGGER_SETUP + 5'(s2_q.step - 16'(PW));
         regs_d[s2_q.axis][cap_idx] = flash_rdata;
      end else if (s2_q.valid && (s2_q.step >= 16'(SET_END))) begin
         // entry 0 seeds the motion parameters
         cap_idx = `MRL_REG_TARGET_POSITION + 5'(s2_q.step - 16'(SET_END));
         regs_d[s2_q.axis][cap_idx] = pm_rdata[s2_q.axis];
      end
      if (!busy && reg_wr && bus_hit) begin
         regs_d[reg_addr[5]][reg_addr[4:0]] = reg_wdata[23:0];
      end
      reg_rdata_d = '0;
      if (reg_rd) begin
         if (reg_addr == `MRL_LDR_STATUS_ADDR) begin
            reg_rdata_d[`MRL_LDR_BUSY_BIT] = busy;
            reg_rdata_d[`MRL_LDR_DONE_BIT] = (st_q == LD_DONE);
         end else if (!busy && bus_hit) begin
            reg_rdata_d = {8'h00, regs_q[reg_addr[5]][reg_addr[4:0]]};
         end
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         for (int a = 0; a < 2; a++) begin
            for (int r = 0; r < `MRL_NUM_REGS; r++) begin
               regs_q[a][r] <= `MRL_ZERO_INIT;
            end
         end
         reg_rdata <= '0;
      end else begin
         regs_q    <= regs_d;
         reg_rdata <= reg_rdata_d;
      end
   end

endmodule

`default_nettype wire

// ---- verification/mrl_loader_props.sv ----
// Port checker of the axis reset loader
`timescale 1ns/100ps
`default_nettype none

module mrl_loader_chk #(
   parameter int N_PAT = 16,
   parameter int FAW   = 12
) (
   input wire logic           mclk,        // System clock
   input wire logic           nrst,        // Reset, active low
   input wire logic [7:0]     reg_addr,    // Register index
   input wire logic [31:0]    reg_wdata,   // Write data
   input wire logic           reg_wr,      // Write strobe
   input wire logic           reg_rd,      // Read strobe
   input wire logic [31:0]    reg_rdata,   // Read data
   input wire logic           busy,        // Loading
   input wire logic [FAW-1:0] flash_addr,  // Flash address
   input wire logic           flash_rd,    // Flash strobe
   input wire logic [23:0]    flash_rdata  // Flash data
);
   localparam int SET_END = N_PAT * 5 + 5;
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;

   // Counts flash words fetched since reset
   always_comb cnt_d = cnt_q + 16'(flash_rd);
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) cnt_q <= 16'h0000;
      else cnt_q <= cnt_d;
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);

   a_busy_refuse: assert property ($past(reg_rd) && $past(busy) && $past(reg_addr) != 8'h3F
      |-> reg_rdata == 32'h0) else $error("register answered while loading");
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside its cycle");
   a_rdata_upper: assert property (reg_rdata[31:24] == 8'h00) else $error("upper read bits set");
   a_busy_sticky: assert property (!busy |=> !busy) else $error("busy rose again");
   a_flash_busy: assert property (flash_rd |-> busy) else $error("flash read after loading");
   a_flash_order: assert property (flash_rd && $past(flash_rd)
      |-> flash_addr == $past(flash_addr) + 1'b1) else $error("flash words out of order");
   a_flash_range: assert property (flash_rd |-> flash_addr < FAW'(2 * SET_END))
      else $error("flash address beyond image");
   a_load_count: assert property ($fell(busy) |-> cnt_q == 16'(2 * SET_END))
      else $error("loading ended with wrong word count");
endmodule

bind mrl_loader mrl_loader_chk #(.N_PAT(N_PAT), .FAW(FAW)) mrl_loader_chk_inst (
   .mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .busy(busy), .flash_addr(flash_addr),
   .flash_rd(flash_rd), .flash_rdata(flash_rdata));

`default_nettype wire

// ---- verification/mrl_flash_model.sv ----
// Flash image model answering the loader's word reads
`timescale 1ns/100ps
`default_nettype none

module mrl_flash_model #(
   parameter int FAW = 12
) (
   input  wire logic           mclk,        // System clock
   input  wire logic [11:0]    image_tag,   // Marks which save left the image
   input  wire logic [FAW-1:0] flash_addr,  // Word address
   input  wire logic           flash_rd,    // Read strobe
   output logic      [23:0]    flash_rdata  // Word, cycle after strobe
);
   // image left by the last save command
   // Outside a read the data toggles so stale words never look valid
   always_ff @(posedge mclk) begin
      if (flash_rd) flash_rdata <= {image_tag, 12'(flash_addr)};
      else flash_rdata <= ~flash_rdata;
   end
endmodule

`default_nettype wire

// ---- verification/test_mrl_loader.sv ----
// Self-checking bench of the axis reset loader
`timescale 1ns/100ps
`default_nettype none

module test_mrl_loader;
   localparam int N_PAT = 2;
   localparam int SET = N_PAT * 5 + 5;
   logic        mclk = 1'b0;
   logic        nrst = 1'b0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic [31:0] reg_rdata;
   logic [31:0] rd_val;
   logic        busy;
   logic        flash_rd;
   logic [11:0] flash_addr;
   logic [23:0] flash_rdata;
   logic [11:0] image_tag = 12'hC35;
   int          fail_count = 0;
   int          n_compared = 0;

   always #25 mclk = ~mclk;

   mrl_loader #(.N_PAT(N_PAT), .FAW(12)) mrl_loader_inst (.mclk(mclk), .nrst(nrst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .busy(busy), .flash_addr(flash_addr), .flash_rd(flash_rd),
      .flash_rdata(flash_rdata));
   mrl_flash_model #(.FAW(12)) mrl_flash_model_inst (.mclk(mclk), .image_tag(image_tag),
      .flash_addr(flash_addr), .flash_rd(flash_rd), .flash_rdata(flash_rdata));

   task automatic complete_run;
      $display("Compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
      @(posedge mclk);
   endtask

   task automatic check_busy;
      reg_read(8'h3F, rd_val);
      cmp(rd_val, 32'h1);
      reg_write(8'h30, 32'h00ABCDEF);
      reg_read(8'h25, rd_val);
      cmp(rd_val, 32'h0);
      for (int i = 0; i < 300 && rd_val !== 32'h2; i++) reg_read(8'h3F, rd_val);
      cmp(rd_val, 32'h2);
      cmp({31'h0, busy}, 32'h0);
   endtask

   task automatic check_load(input logic [11:0] tag);
      logic [31:0] e;
      for (int ax = 0; ax < 2; ax++) begin
         for (int r = 0; r < 17; r++) begin
            e = 32'h0;
            if (r >= 5 && r <= 9) e = {8'h00, tag, 12'(ax * SET + r - 5)};
            if (r >= 11 && r <= 15) e = {8'h00, tag, 12'(ax * SET + r - 1)};
            reg_read({2'b00, ax[0], r[4:0]}, rd_val);
            cmp(rd_val, e);
         end
      end
   endtask

   task automatic check_access;
      reg_write(8'h25, 32'hFF123456);
      reg_read(8'h25, rd_val);
      cmp(rd_val, 32'h00123456);
      reg_read(8'h11, rd_val);
      cmp(rd_val, 32'h0);
      reg_write(8'h3F, 32'h0);
      reg_read(8'h3F, rd_val);
      cmp(rd_val, 32'h2);
   endtask

   // A later save leaves a new image; a reset after loading has finished must clear and reload from it
   task automatic check_reload;
      reg_write(8'h21, 32'h00654321);
      reg_write(8'h0B, 32'h00777777);
      reg_read(8'h21, rd_val);
      cmp(rd_val, 32'h00654321);
      image_tag <= 12'h5A3;
      nrst <= 1'b0;
      repeat (4) @(posedge mclk);
      nrst <= 1'b1;
      check_busy();
      check_load(12'h5A3);
   endtask

   initial begin
      repeat (16) @(posedge mclk);
      nrst <= 1'b1;
      check_busy();
      check_load(12'hC35);
      check_access();
      check_reload();
      complete_run();
   end

   initial begin
      #100000;
      fail_count++;
      complete_run();
   end
endmodule

`default_nettype wire
